//--- lockout_defs.svh
// constants for the panel pin lockout block
`ifndef LOCKOUT_DEFS_SVH
`define LOCKOUT_DEFS_SVH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define ADDR_W            8
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STATUS    8'h08
`define REG_IRQ_MASK      8'h0c
`define REG_PIN_VIEW      8'h10

`define CTRL_CLEAR_BIT    0

`define STATUS_ARMED_BIT  3
`define STATUS_VALID_BIT  4
`define STATUS_NOTICE_BIT 5
`define STATUS_KEY_BIT    6

`define EV_W              4
`define EV_LOCK           0
`define EV_UNLOCK         1
`define EV_WRONG          2
`define EV_PROMPT         3

`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

// -----------------------------------------------------------------
// pin value, four bcd digits
// -----------------------------------------------------------------
`define PIN_W             16
`define DIGITS            4
`define PIN_ZERO          16'h0000
`define PIN_MIN           16'h0001
`define PIN_MAX           16'h9999
`define DIGIT_MAX         4'h9
`define DIGIT_ZERO        4'h0
`define DIGIT_ONE         4'h1

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define FLASH_TIME_MS     500
`define CLK_FREQ_KHZ      50000
`define FLASH_CYCLES      (`FLASH_TIME_MS * `CLK_FREQ_KHZ)
`define FLASH_CNT_W       25
`define FLASH_BLINK_BIT   22

`endif

//--- lockout_pkg.sv
// types shared by the panel pin lockout block
`include "lockout_defs.svh"
package lockout_pkg;

   // -----------------------------------------------------------------
   // enumerations
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OPERATE = 3'b001,
      ST_PROGRAM = 3'b010,
      ST_PROMPT  = 3'b100
   } panel_state_t;

   typedef enum logic [2:0] {
      DISP_VALUE  = 3'h0,
      DISP_LOCK   = 3'h1,
      DISP_UNLOCK = 3'h2,
      DISP_WRONG  = 3'h3,
      DISP_PROMPT = 3'h4
   } disp_code_t;

   // -----------------------------------------------------------------
   // module state records
   // -----------------------------------------------------------------
   typedef struct packed {
      logic                     busy;
      logic                     done;
      logic [`FLASH_CNT_W-1:0]  cnt;
   } flash_state_t;

   typedef struct packed {
      panel_state_t             st;
      logic                     armed;
      logic                     arm_notice;
      logic [`PIN_W-1:0]        pin;
      logic [`PIN_W-1:0]        entry;
      logic [`PIN_W-1:0]        disp_value;
      disp_code_t               disp_code;
      logic                     flash_start;
      logic                     boot;
      logic                     prog_q;
      logic                     enter_q;
      logic                     inc_q;
      logic                     dec_q;
      logic [`EV_W-1:0]         irq_sts;
      logic [`EV_W-1:0]         irq_mask;
      logic                     aw_full;
      logic [`ADDR_W-1:0]       aw_addr;
      logic                     w_full;
      logic [31:0]              w_data;
      logic [3:0]               w_strb;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     rvalid;
      logic [31:0]              rdata;
      logic [1:0]               rresp;
   } lock_state_t;

endpackage

//--- flash_timer.sv
// one-shot display flash timer with a blink phase
`timescale 1ns/1ps
`include "lockout_defs.svh"

module flash_timer #(
   parameter logic [`FLASH_CNT_W-1:0] CYCLES = `FLASH_CNT_W'(`FLASH_CYCLES)
) (
   input  wire logic aclk,     // system clock
   input  wire logic aresetn,  // sync reset, low
   input  wire logic start,    // restart the flash
   output logic      busy,     // flash running
   output logic      blink,    // blink phase
   output logic      done      // one-cycle end pulse
);

   lockout_pkg::flash_state_t s;
   lockout_pkg::flash_state_t next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      if (start) begin
         next_s.busy = 1'b1;
         next_s.cnt  = CYCLES - `FLASH_CNT_W'(1);
      end else if (s.busy) begin
         if (s.cnt == '0) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt - `FLASH_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy  = s.busy;
   assign blink = s.cnt[`FLASH_BLINK_BIT];
   assign done  = s.done;

endmodule

//--- pin_program_lockout.sv
// front-panel pin lockout of program mode, with axi4-lite registers
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "lockout_defs.svh"

module pin_program_lockout #(
   parameter logic [`FLASH_CNT_W-1:0] FLASH_CYCLES = `FLASH_CNT_W'(`FLASH_CYCLES)
) (
   input  wire logic                 aclk,           // system clock
   input  wire logic                 aresetn,        // sync reset, low
   input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,   // write address
   input  wire logic                 s_axi_awvalid,  // write address valid
   output logic                      s_axi_awready,  // write address ready
   input  wire logic [31:0]          s_axi_wdata,    // write data
   input  wire logic [3:0]           s_axi_wstrb,    // write strobes
   input  wire logic                 s_axi_wvalid,   // write data valid
   output logic                      s_axi_wready,   // write data ready
   output logic [1:0]                s_axi_bresp,    // write response
   output logic                      s_axi_bvalid,   // write response valid
   input  wire logic                 s_axi_bready,   // write response ready
   input  wire logic [`ADDR_W-1:0]   s_axi_araddr,   // read address
   input  wire logic                 s_axi_arvalid,  // read address valid
   output logic                      s_axi_arready,  // read address ready
   output logic [31:0]               s_axi_rdata,    // read data
   output logic [1:0]                s_axi_rresp,    // read response
   output logic                      s_axi_rvalid,   // read data valid
   input  wire logic                 s_axi_rready,   // read data ready
   input  wire logic                 prog_btn,       // program/operate button
   input  wire logic                 enter_btn,      // enter button
   input  wire logic                 inc_btn,        // data up button
   input  wire logic                 dec_btn,        // data down button
   input  wire logic                 pin_param_sel,  // pin parameter selected
   input  wire logic                 key_lock,       // hardware key in lock
   input  wire logic                 key_unlock,     // hardware key operated
   input  wire logic                 estop_reset,    // e-stop reset pulse
   input  wire logic                 clear_code_req, // clear extended data
   input  wire logic                 nv_restore,     // load from nv store
   input  wire logic [`PIN_W-1:0]    nv_pin_in,      // nv stored pin
   input  wire logic                 nv_armed_in,    // nv stored armed
   output logic                      program_mode,   // in program mode
   output logic                      locked,         // lockout armed
   output logic                      prog_led,       // program led
   output lockout_pkg::disp_code_t   disp_code,      // display message
   output logic [`PIN_W-1:0]         disp_value,     // display digits
   output logic [`PIN_W-1:0]         nv_pin,         // pin to nv store
   output logic                      nv_armed,       // armed to nv store
   output logic                      irq             // interrupt, high
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [`PIN_W-1:0] bcd_inc(input logic [`PIN_W-1:0] v);
      logic [`PIN_W-1:0] r;
      logic              carry;
      r     = v;
      carry = 1'b1;
      if (v != `PIN_MAX) begin
         for (int i = 0; i < `DIGITS; i++) begin
            if (carry) begin
               if (v[i*4 +: 4] == `DIGIT_MAX) begin
                  r[i*4 +: 4] = `DIGIT_ZERO;
               end else begin
                  r[i*4 +: 4] = v[i*4 +: 4] + `DIGIT_ONE;
                  carry       = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   function automatic logic [`PIN_W-1:0] bcd_dec(input logic [`PIN_W-1:0] v);
      logic [`PIN_W-1:0] r;
      logic              borrow;
      r      = v;
      borrow = 1'b1;
      if (v <= `PIN_MIN) begin
         r = `PIN_MIN;
      end else begin
         for (int i = 0; i < `DIGITS; i++) begin
            if (borrow) begin
               if (v[i*4 +: 4] == `DIGIT_ZERO) begin
                  r[i*4 +: 4] = `DIGIT_MAX;
               end else begin
                  r[i*4 +: 4] = v[i*4 +: 4] - `DIGIT_ONE;
                  borrow      = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   lockout_pkg::lock_state_t s;
   lockout_pkg::lock_state_t next_s;
   logic                     flash_busy;
   logic                     flash_blink;
   logic                     flash_done;

   flash_timer #(
      .CYCLES (FLASH_CYCLES)
   ) u_flash (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (s.flash_start),
      .busy    (flash_busy),
      .blink   (flash_blink),
      .done    (flash_done)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic                prog_rise;
      logic                prog_fall;
      logic                enter_rise;
      logic                enter_fall;
      logic                inc_rise;
      logic                dec_rise;
      logic                sw_clear;
      logic                rd_clear;
      logic [`EV_W-1:0]    ev;
      logic [31:0]         rd;
      prog_rise  = prog_btn & ~s.prog_q;
      prog_fall  = ~prog_btn & s.prog_q;
      enter_rise = enter_btn & ~s.enter_q;
      enter_fall = ~enter_btn & s.enter_q;
      inc_rise   = inc_btn & ~s.inc_q;
      dec_rise   = dec_btn & ~s.dec_q;
      sw_clear   = 1'b0;
      rd_clear   = 1'b0;
      ev         = '0;
      rd         = '0;

      next_s             = s;
      next_s.flash_start = 1'b0;
      next_s.boot        = 1'b0;
      next_s.prog_q      = prog_btn;
      next_s.enter_q     = enter_btn;
      next_s.inc_q       = inc_btn;
      next_s.dec_q       = dec_btn;
      if (flash_done) begin
         next_s.disp_code = lockout_pkg::DISP_VALUE;
      end

      // axi write: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_full = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end
      if (s.aw_full && s.w_full && !s.bvalid) begin
         next_s.aw_full = 1'b0;
         next_s.w_full  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = `RESP_OKAY;
         case (s.aw_addr)
            `REG_CTRL: begin
               sw_clear = s.w_strb[0] & s.w_data[`CTRL_CLEAR_BIT];
            end
            `REG_IRQ_MASK: begin
               if (s.w_strb[0]) begin
                  next_s.irq_mask = s.w_data[`EV_W-1:0];
               end
            end
            `REG_STATUS, `REG_IRQ_STATUS, `REG_PIN_VIEW: begin
            end
            default: begin
               next_s.bresp = `RESP_DECERR;
            end
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // axi read
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = `RESP_OKAY;
         case (s_axi_araddr)
            `REG_CTRL: begin
            end
            `REG_STATUS: begin
               rd[2:0]                = s.st;
               rd[`STATUS_ARMED_BIT]  = s.armed;
               rd[`STATUS_VALID_BIT]  = (s.pin != `PIN_ZERO);
               rd[`STATUS_NOTICE_BIT] = s.arm_notice;
               rd[`STATUS_KEY_BIT]    = key_lock;
            end
            `REG_IRQ_STATUS: begin
               rd[`EV_W-1:0] = s.irq_sts;
               rd_clear      = 1'b1;
            end
            `REG_IRQ_MASK: begin
               rd[`EV_W-1:0] = s.irq_mask;
            end
            `REG_PIN_VIEW: begin
               rd[`PIN_W-1:0] = s.disp_value;
            end
            default: begin
               next_s.rresp = `RESP_DECERR;
            end
         endcase
         next_s.rdata = rd;
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      // -----------------------------------------------------------------
      // panel sequence
      // -----------------------------------------------------------------
      case (s.st)
         lockout_pkg::ST_OPERATE: begin
            if (prog_rise && s.armed && !s.arm_notice && !key_unlock && !key_lock) begin
               next_s.st          = lockout_pkg::ST_PROMPT;
               next_s.entry       = `PIN_ZERO;
               next_s.disp_code   = lockout_pkg::DISP_PROMPT;
               next_s.flash_start = 1'b1;
               ev[`EV_PROMPT]     = 1'b1;
            end else if (prog_fall && !key_lock) begin
               if (!s.armed || key_unlock) begin
                  next_s.st         = lockout_pkg::ST_PROGRAM;
                  next_s.armed      = 1'b0;
                  next_s.arm_notice = 1'b0;
                  next_s.entry      = s.pin;
               end else if (s.arm_notice) begin
                  next_s.arm_notice  = 1'b0;
                  next_s.disp_code   = lockout_pkg::DISP_LOCK;
                  next_s.flash_start = 1'b1;
                  ev[`EV_LOCK]       = 1'b1;
               end
            end
         end
         lockout_pkg::ST_PROGRAM: begin
            if (pin_param_sel && inc_rise) begin
               next_s.entry = bcd_inc(s.entry);
            end else if (pin_param_sel && dec_rise) begin
               next_s.entry = bcd_dec(s.entry);
            end
            if (pin_param_sel && enter_rise && s.entry != `PIN_ZERO) begin
               next_s.pin = s.entry;
            end
            if (prog_fall) begin
               next_s.st         = lockout_pkg::ST_OPERATE;
               next_s.armed      = (next_s.pin != `PIN_ZERO);
               next_s.arm_notice = (next_s.pin != `PIN_ZERO);
               next_s.entry      = `PIN_ZERO;
            end
         end
         lockout_pkg::ST_PROMPT: begin
            if (inc_rise) begin
               next_s.entry = bcd_inc(s.entry);
            end else if (dec_rise) begin
               next_s.entry = bcd_dec(s.entry);
            end
            if (key_unlock && !key_lock) begin
               next_s.st    = lockout_pkg::ST_PROGRAM;
               next_s.armed = 1'b0;
               next_s.entry = s.pin;
            end else if (enter_fall) begin
               next_s.flash_start = 1'b1;
               if (s.entry == s.pin && !key_lock) begin
                  next_s.st        = lockout_pkg::ST_PROGRAM;
                  next_s.armed     = 1'b0;
                  next_s.disp_code = lockout_pkg::DISP_UNLOCK;
                  ev[`EV_UNLOCK]   = 1'b1;
               end else begin
                  next_s.disp_code = lockout_pkg::DISP_WRONG;
                  next_s.entry     = `PIN_ZERO;
                  ev[`EV_WRONG]    = 1'b1;
               end
            end else if (prog_rise) begin
               next_s.st    = lockout_pkg::ST_OPERATE;
               next_s.entry = `PIN_ZERO;
            end
         end
         default: begin
            next_s.st = lockout_pkg::ST_OPERATE;
         end
      endcase

      // nonvolatile restore, then clearing has the last word
      if (nv_restore) begin
         next_s.pin   = nv_pin_in;
         next_s.armed = nv_armed_in && (nv_pin_in != `PIN_ZERO);
      end
      if (clear_code_req || sw_clear || (s.boot && prog_btn) || (estop_reset && prog_btn)) begin
         next_s.pin        = `PIN_ZERO;
         next_s.armed      = 1'b0;
         next_s.arm_notice = 1'b0;
         if (s.st == lockout_pkg::ST_PROMPT) begin
            next_s.st = lockout_pkg::ST_OPERATE;
         end
      end

      // event set wins over read clear
      next_s.irq_sts    = (rd_clear ? '0 : s.irq_sts) | ev;
      next_s.disp_value = (next_s.st == lockout_pkg::ST_OPERATE) ? `PIN_ZERO : next_s.entry;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s      <= '0;
         s.st   <= lockout_pkg::ST_OPERATE;
         s.boot <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign s_axi_awready = ~s.aw_full & ~s.bvalid;
   assign s_axi_wready  = ~s.w_full & ~s.bvalid;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_arready = ~s.rvalid;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;
   assign program_mode  = (s.st == lockout_pkg::ST_PROGRAM);
   assign locked        = s.armed;
   assign prog_led      = program_mode |
                          ((s.disp_code == lockout_pkg::DISP_PROMPT) & flash_busy & flash_blink);
   assign disp_code     = s.disp_code;
   assign disp_value    = s.disp_value;
   assign nv_pin        = s.pin;
   assign nv_armed      = s.armed;
   assign irq           = |(s.irq_sts & s.irq_mask);

endmodule

//--- pin_program_lockout_assertions.sv
// port assertions for the pin lockout block
`timescale 1ns/1ps
`include "lockout_defs.svh"
module pin_program_lockout_assertions #(
   parameter logic [`FLASH_CNT_W-1:0] FLASH_CYCLES = `FLASH_CNT_W'(`FLASH_CYCLES)
) (
   input wire logic                    aclk,          // clock
   input wire logic                    aresetn,       // reset, low
   input wire logic                    s_axi_awready, // aw ready
   input wire logic                    s_axi_wready,  // w ready
   input wire logic [1:0]              s_axi_bresp,   // b response
   input wire logic                    s_axi_bvalid,  // b valid
   input wire logic                    s_axi_bready,  // b ready
   input wire logic                    s_axi_arready, // ar ready
   input wire logic                    s_axi_rvalid,  // r valid
   input wire logic                    s_axi_rready,  // r ready
   input wire logic                    key_lock,      // key in lock
   input wire logic                    program_mode,  // program mode
   input wire logic                    locked,        // lockout armed
   input wire logic                    prog_led,      // program led
   input wire lockout_pkg::disp_code_t disp_code,     // message
   input wire logic [`PIN_W-1:0]       disp_value     // digits
);
   // ----
   // bus and panel properties
   // ----
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   a_key_blocks: assert property (key_lock && !program_mode |=> !program_mode)
      else $error("program entered with key in lock");
   a_locked_out: assert property (locked |-> !program_mode)
      else $error("program mode while locked");
   a_pin_hidden: assert property ($changed(disp_code) && disp_code == lockout_pkg::DISP_PROMPT
      |-> disp_value == 16'h0000) else $error("prompt shows digits");
   a_unlock_enters: assert property ($changed(disp_code) && disp_code == lockout_pkg::DISP_UNLOCK
      |-> program_mode && !locked) else $error("unlock without program");
   a_wrong_stays: assert property (disp_code == lockout_pkg::DISP_WRONG |-> !program_mode)
      else $error("wrong pin entered program");
   a_led_program: assert property (program_mode |-> prog_led)
      else $error("program led off");
endmodule

//--- panel_model.sv
// front panel buttons and key switch model
`timescale 1ns/1ps
module panel_model (
   input  wire logic aclk,          // clock
   output logic      prog_btn,      // program/operate
   output logic      enter_btn,     // enter
   output logic      inc_btn,       // data up
   output logic      dec_btn,       // data down
   output logic      pin_param_sel, // pin parameter shown
   output logic      key_lock,      // key in lock
   output logic      key_unlock     // key operated
);
   logic [3:0] btn;

   assign {dec_btn, inc_btn, enter_btn, prog_btn} = btn;
   initial begin
      btn = 4'h0;
      {pin_param_sel, key_lock, key_unlock} = 3'h0;
   end

   // press and release one button, index 0 prog 1 enter 2 up 3 down
   task automatic press(input int i);
      @(posedge aclk);
      btn[i] <= 1'b1;
      repeat (3) @(posedge aclk);
      btn[i] <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
endmodule

//--- pin_program_lockout_tb.sv
// self-checking bench for the pin lockout block
`timescale 1ns/1ps
`include "lockout_defs.svh"
module pin_program_lockout_tb;
   localparam logic [`FLASH_CNT_W-1:0] FLASH = `FLASH_CNT_W'(64);
   localparam int PR = 0, EN = 1, UP = 2, DN = 3;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, prog_btn, enter_btn, inc_btn, dec_btn, pin_param_sel, key_lock;
   logic key_unlock, program_mode, locked, prog_led, nv_armed, irq;
   logic estop_reset, clear_code_req, nv_restore;
   logic [`ADDR_W-1:0]      s_axi_awaddr, s_axi_araddr;
   logic [31:0]             s_axi_wdata, s_axi_rdata;
   logic [3:0]              s_axi_wstrb;
   logic [1:0]              s_axi_bresp, s_axi_rresp;
   logic [`PIN_W-1:0]       disp_value, nv_pin;
   lockout_pkg::disp_code_t disp_code;
   int                      mismatches = 0, n_checks = 0;

   pin_program_lockout #(.FLASH_CYCLES(FLASH)) u_pin_program_lockout (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_btn, .enter_btn, .inc_btn,
      .dec_btn, .pin_param_sel, .key_lock, .key_unlock, .estop_reset,
      .clear_code_req, .nv_restore, .nv_pin_in(16'h0042),
      .nv_armed_in(1'b1), .program_mode, .locked, .prog_led, .disp_code,
      .disp_value, .nv_pin, .nv_armed, .irq);
   panel_model u_panel_model (.aclk, .prog_btn, .enter_btn, .inc_btn, .dec_btn,
      .pin_param_sel, .key_lock, .key_unlock);

   // ----
   // tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask

   task automatic p(input int i, input int n);
      repeat (n) u_panel_model.press(i);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----
   // clock, watchdog, tests
   // ----
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      give_verdict();
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, estop_reset, clear_code_req, nv_restore} = '0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(locked, 1'b0);
      chk(nv_pin, 16'h0000);
      rd(`REG_STATUS, 32'h1, `RESP_OKAY);
      rd(8'h20, 32'h0, `RESP_DECERR);
      wr(`REG_IRQ_MASK, 32'hf, `RESP_OKAY);
      rd(`REG_IRQ_MASK, 32'hf, `RESP_OKAY);
      p(PR, 1);
      chk(program_mode, 1'b1);
      u_panel_model.pin_param_sel <= 1'b1;
      p(UP, 1);
      p(DN, 1);
      chk(disp_value, 16'h0001);
      p(UP, 2);
      p(EN, 1);
      chk(nv_pin, 16'h0003);
      u_panel_model.pin_param_sel <= 1'b0;
      p(PR, 1);
      chk(locked, 1'b1);
      p(PR, 1);
      chk(disp_code, lockout_pkg::DISP_LOCK);
      chk(program_mode, 1'b0);
      repeat (70) @(posedge aclk);
      p(PR, 1);
      chk(disp_code, lockout_pkg::DISP_PROMPT);
      chk(disp_value, 16'h0000);
      repeat (70) @(posedge aclk);
      p(UP, 2);
      p(EN, 1);
      chk(disp_code, lockout_pkg::DISP_WRONG);
      chk(program_mode, 1'b0);
      repeat (70) @(posedge aclk);
      p(UP, 3);
      p(EN, 1);
      chk(disp_code, lockout_pkg::DISP_UNLOCK);
      chk(program_mode, 1'b1);
      chk(irq, 1'b1);
      rd(`REG_IRQ_STATUS, 32'hf, `RESP_OKAY);
      @(posedge aclk);
      chk(irq, 1'b0);
      p(PR, 1);
      chk(locked, 1'b1);
      wr(`REG_CTRL, 32'h1, `RESP_OKAY);
      @(posedge aclk);
      chk(locked, 1'b0);
      chk(nv_pin, 16'h0000);
      u_panel_model.key_lock <= 1'b1;
      p(PR, 1);
      chk(program_mode, 1'b0);
      u_panel_model.key_lock <= 1'b0;
      repeat (70) @(posedge aclk);
      u_panel_model.key_unlock <= 1'b1;
      p(PR, 1);
      chk(program_mode, 1'b1);
      wr(8'h20, 32'h0, `RESP_DECERR);
      p(PR, 1);
      nv_restore <= 1'b1;
      @(posedge aclk);
      nv_restore <= 1'b0;
      @(posedge aclk);
      chk({nv_armed, nv_pin}, 32'h10042);
      clear_code_req <= 1'b1;
      @(posedge aclk);
      clear_code_req <= 1'b0;
      @(posedge aclk);
      chk(nv_pin, 16'h0000);
      u_panel_model.btn[0] <= 1'b1;
      {estop_reset, nv_restore} <= 2'h3;
      @(posedge aclk);
      {estop_reset, nv_restore} <= 2'h0;
      @(posedge aclk);
      chk(nv_pin, 16'h0000);
      give_verdict();
   end
endmodule

bind pin_program_lockout pin_program_lockout_assertions #(.FLASH_CYCLES(FLASH_CYCLES)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_lock(key_lock),
   .program_mode(program_mode), .locked(locked), .prog_led(prog_led),
   .disp_code(disp_code), .disp_value(disp_value));
